//--- verilog/udwr_dma_req.v
// watermark driven dma burst and single request generator for uart fifos
//
// Added by the designer: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
`include "udwr_defs.vh"
////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// RQ1 - tx burst request when tx fill <= watermark
// RQ2 - controller writes dest_burst_len words per request
// RQ3 - tx trigger code 01 means 2 entries
// RQ4 - tx trigger code 11 means half depth
// RQ5 - dest_burst_len at most depth minus tx watermark
// RQ6 - dest_burst_len ideally equals depth minus watermark
// RQ7 - rx burst request when rx fill >= trigger
// RQ8 - controller reads src_burst_len words per request
// RQ9 - src_burst_len at most rx watermark, ideally equal
// RQ10 - tx pops continue during a dma burst
// RQ11 - rx pushes continue during a dma burst
// RQ12 - controller uses byte wide transfers
// RQ13 - drop request on ack, rearm after ack release
// RQ14 - tx single while tx fifo not full
// RQ15 - rx single while rx fifo not empty
// RQ16 - other trigger codes decode to fixed levels
// RQ17 - bus clock only, requests inactive in reset
////////////////////////////////////////////////////////////////////////////////
module udwr_dma_req #(
  parameter                 DEPTH = `UDWR_FIFO_DEPTH,
  parameter                 CNT_W = `UDWR_CNT_W
) (
  input  wire               clk_i,
  input  wire               reset_i,
  // avalon-mm slave
  input  wire [3:0]         avs_address_i,
  input  wire               avs_read_i,
  input  wire               avs_write_i,
  input  wire [31:0]        avs_writedata_i,
  output wire [31:0]        avs_readdata_o,
  output wire               avs_waitrequest_o,
  // fifo occupancy events
  input  wire               tx_push_i,
  input  wire               tx_pop_i,
  input  wire               rx_push_i,
  input  wire               rx_pop_i,
  // dma handshake, active low
  input  wire               dma_tx_ack_n_i,
  input  wire               dma_rx_ack_n_i,
  output wire               dma_tx_req_n_o,
  output wire               dma_rx_req_n_o,
  output wire               dma_tx_single_n_o,
  output wire               dma_rx_single_n_o
);

  // levels worked out at 32 bits, then cut to the counter width on purpose
  localparam [31:0]      FULL_W   = DEPTH;
  localparam [31:0]      HALF_W   = DEPTH / 2;
  localparam [31:0]      QTR_W    = DEPTH / 4;
  localparam [31:0]      TWO_W    = `UDWR_TX_LVL_01;
  localparam [31:0]      NTWO_W   = DEPTH - 2;
  localparam [CNT_W-1:0] LVL_FULL = FULL_W[CNT_W-1:0];
  localparam [CNT_W-1:0] LVL_HALF = HALF_W[CNT_W-1:0];
  localparam [CNT_W-1:0] LVL_QTR  = QTR_W[CNT_W-1:0];
  localparam [CNT_W-1:0] LVL_TWO  = TWO_W[CNT_W-1:0];
  localparam [CNT_W-1:0] LVL_NTWO = NTWO_W[CNT_W-1:0];
  localparam [CNT_W-1:0] LVL_ONE  = {{(CNT_W-1){1'b0}}, 1'b1};
  localparam [CNT_W-1:0] LVL_ZERO = {CNT_W{1'b0}};

  //////////////////////////////////////////////////////////////////////////////
  // trigger decoding
  // transmit watermark: empty, two entries, quarter, half
  function [CNT_W-1:0] tx_level;
    input [1:0] code;
    begin
      case (code)
        `UDWR_TRIG_00: tx_level = LVL_ZERO; // RQ16
        `UDWR_TRIG_01: tx_level = LVL_TWO;  // RQ3
        `UDWR_TRIG_10: tx_level = LVL_QTR;  // RQ16
        `UDWR_TRIG_11: tx_level = LVL_HALF; // RQ4
        default:       tx_level = LVL_ZERO;
      endcase
    end
  endfunction

  // receive watermark: one entry, quarter, half, two short of full
  function [CNT_W-1:0] rx_level;
    input [1:0] code;
    begin
      case (code)
        `UDWR_TRIG_00: rx_level = LVL_ONE;  // RQ16
        `UDWR_TRIG_01: rx_level = LVL_QTR;  // RQ16
        `UDWR_TRIG_10: rx_level = LVL_HALF; // RQ16
        `UDWR_TRIG_11: rx_level = LVL_NTWO; // RQ16
        default:       rx_level = LVL_ONE;
      endcase
    end
  endfunction

  // next occupancy; an illegal push or pop is dropped, not wrapped
  function [CNT_W-1:0] next_count;
    input [CNT_W-1:0] cnt;
    input             push;
    input             pop;
    begin
      next_count = cnt;
      if (push && !pop && cnt != LVL_FULL) begin
        next_count = cnt + LVL_ONE;
      end else if (pop && !push && cnt != LVL_ZERO) begin
        next_count = cnt - LVL_ONE;
      end
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // state
  reg  [7:0]       fifo_ctrl_ff;
  reg  [CNT_W-1:0] tx_count_ff;
  reg  [CNT_W-1:0] rx_count_ff;
  reg              tx_ovf_ff;
  reg              rx_unf_ff;
  reg              tx_req_n_ff;
  reg              rx_req_n_ff;
  reg              tx_single_n_ff;
  reg              rx_single_n_ff;
  reg  [31:0]      rdata_ff;
  reg              wait_ff;

  wire             enable  = fifo_ctrl_ff[`UDWR_FC_ENABLE];
  wire [1:0]       tx_code = fifo_ctrl_ff[`UDWR_FC_TXTRIG_HI:`UDWR_FC_TXTRIG_LO];
  wire [1:0]       rx_code = fifo_ctrl_ff[`UDWR_FC_RXTRIG_HI:`UDWR_FC_RXTRIG_LO];
  wire             tx_ack  = ~dma_tx_ack_n_i;
  wire             rx_ack  = ~dma_rx_ack_n_i;
  wire             bus_req = avs_read_i | avs_write_i;
  // access completes at the edge where waitrequest is seen low
  wire             wr_done = avs_write_i & ~wait_ff;

  wire             tx_mark = enable && (tx_count_ff <= tx_level(tx_code)); // RQ1
  wire             rx_mark = enable && (rx_count_ff >= rx_level(rx_code)); // RQ7

  reg  [31:0]      nxt_rdata;

  //////////////////////////////////////////////////////////////////////////////
  // avalon slave: one wait cycle, then answer
  always @* begin
    nxt_rdata = 32'h0000_0000;
    case (avs_address_i)
      `UDWR_OFS_FIFO_CTRL: begin
        nxt_rdata[7:0] = fifo_ctrl_ff;
      end
      `UDWR_OFS_STATUS: begin
        nxt_rdata[`UDWR_ST_TXCNT_LO +: CNT_W] = tx_count_ff;
        nxt_rdata[`UDWR_ST_RXCNT_LO +: CNT_W] = rx_count_ff;
        nxt_rdata[`UDWR_ST_TX_REQ]            = ~tx_req_n_ff;
        nxt_rdata[`UDWR_ST_RX_REQ]            = ~rx_req_n_ff;
        nxt_rdata[`UDWR_ST_TX_SINGLE]         = ~tx_single_n_ff;
        nxt_rdata[`UDWR_ST_RX_SINGLE]         = ~rx_single_n_ff;
      end
      `UDWR_OFS_ERROR: begin
        nxt_rdata[`UDWR_ER_TX_OVF] = tx_ovf_ff;
        nxt_rdata[`UDWR_ER_RX_UNF] = rx_unf_ff;
      end
      default: begin
        nxt_rdata = 32'h0000_0000; // unmapped reads as zero
      end
    endcase
  end

  // waitrequest idles high so a new request always waits one edge
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      wait_ff  <= 1'b1;
      rdata_ff <= 32'h0000_0000;
    end else begin
      wait_ff <= ~(bus_req & wait_ff);
      if (avs_read_i && wait_ff) begin
        rdata_ff <= nxt_rdata;
      end
    end
  end

  // control register write
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      fifo_ctrl_ff <= `UDWR_FC_RESET;
    end else if (wr_done && avs_address_i == `UDWR_OFS_FIFO_CTRL) begin
      fifo_ctrl_ff <= avs_writedata_i[7:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // occupancy tracking; serial side keeps moving during bursts
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      tx_count_ff <= LVL_ZERO;
      rx_count_ff <= LVL_ZERO;
    end else begin
      tx_count_ff <= next_count(tx_count_ff, tx_push_i, tx_pop_i); // RQ10
      rx_count_ff <= next_count(rx_count_ff, rx_push_i, rx_pop_i); // RQ11
    end
  end

  // sticky error flags; a new event beats a same cycle clear
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      tx_ovf_ff <= 1'b0;
      rx_unf_ff <= 1'b0;
    end else begin
      if (tx_push_i && !tx_pop_i && tx_count_ff == LVL_FULL) begin
        tx_ovf_ff <= 1'b1;
      end else if (wr_done && avs_address_i == `UDWR_OFS_ERROR &&
                   avs_writedata_i[`UDWR_ER_TX_OVF]) begin
        tx_ovf_ff <= 1'b0;
      end
      if (rx_pop_i && !rx_push_i && rx_count_ff == LVL_ZERO) begin
        rx_unf_ff <= 1'b1;
      end else if (wr_done && avs_address_i == `UDWR_OFS_ERROR &&
                   avs_writedata_i[`UDWR_ER_RX_UNF]) begin
        rx_unf_ff <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // burst requests: held until ack even if the level moves away,
  // dropped while ack is low, rearmed from the level once ack rises
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      tx_req_n_ff <= 1'b1; // RQ17
      rx_req_n_ff <= 1'b1; // RQ17
    end else begin
      tx_req_n_ff <= tx_ack | (tx_req_n_ff & ~tx_mark); // RQ13
      rx_req_n_ff <= rx_ack | (rx_req_n_ff & ~rx_mark); // RQ13
    end
  end

  // single requests follow fifo space and data
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      tx_single_n_ff <= 1'b1; // RQ17
      rx_single_n_ff <= 1'b1; // RQ17
    end else begin
      tx_single_n_ff <= !enable || (tx_count_ff == LVL_FULL); // RQ14
      rx_single_n_ff <= !enable || (rx_count_ff == LVL_ZERO); // RQ15
    end
  end

  // flops kept active low so no gate sits between flop and pin
  assign dma_tx_req_n_o    = tx_req_n_ff;
  assign dma_rx_req_n_o    = rx_req_n_ff;
  assign dma_tx_single_n_o = tx_single_n_ff;
  assign dma_rx_single_n_o = rx_single_n_ff;
  assign avs_readdata_o    = rdata_ff;
  assign avs_waitrequest_o = wait_ff;

endmodule // udwr_dma_req
`default_nettype wire

//--- verilog/udwr_defs.vh
// constants for the uart dma watermark request block
`ifndef UDWR_DEFS_VH
`define UDWR_DEFS_VH

// register byte offsets
`define UDWR_OFS_FIFO_CTRL   4'h0
`define UDWR_OFS_STATUS      4'h4
`define UDWR_OFS_ERROR       4'h8

// fifo_control_reg fields
`define UDWR_FC_ENABLE       0
`define UDWR_FC_TXTRIG_HI    5
`define UDWR_FC_TXTRIG_LO    4
`define UDWR_FC_RXTRIG_HI    7
`define UDWR_FC_RXTRIG_LO    6
`define UDWR_FC_RESET        8'h00

// status register fields
`define UDWR_ST_TXCNT_LO     0
`define UDWR_ST_RXCNT_LO     8
`define UDWR_ST_TX_REQ       16
`define UDWR_ST_RX_REQ       17
`define UDWR_ST_TX_SINGLE    18
`define UDWR_ST_RX_SINGLE    19

// error register fields, write one to clear
`define UDWR_ER_TX_OVF       0
`define UDWR_ER_RX_UNF       1

// trigger codes
`define UDWR_TRIG_00         2'h0
`define UDWR_TRIG_01         2'h1
`define UDWR_TRIG_10         2'h2
`define UDWR_TRIG_11         2'h3

// fixed transmit watermark for code 01
`define UDWR_TX_LVL_01       2

// fifo geometry defaults
`define UDWR_FIFO_DEPTH      16
`define UDWR_CNT_W           5

`endif

//--- verif/udwr_dma_req_asserts.sv
// assertion checker for the uart dma watermark request block
`timescale 1ns/1ps
`default_nettype none
module udwr_dma_req_asserts #(
  parameter DEPTH = 16,
  parameter CNT_W = 5
) (
  input wire logic             clk_i,
  input wire logic             reset_i,
  input wire logic             avs_read_i,
  input wire logic             avs_write_i,
  input wire logic             avs_waitrequest_o,
  input wire logic [3:0]       avs_address_i,
  input wire logic [31:0]      avs_writedata_i,
  input wire logic             tx_push_i,
  input wire logic             tx_pop_i,
  input wire logic             rx_push_i,
  input wire logic             rx_pop_i,
  input wire logic             dma_tx_ack_n_i,
  input wire logic             dma_rx_ack_n_i,
  input wire logic             dma_tx_req_n_o,
  input wire logic             dma_rx_req_n_o,
  input wire logic             dma_tx_single_n_o,
  input wire logic             dma_rx_single_n_o
);
  logic [7:0]       fc_ff;
  logic [CNT_W-1:0] tc_ff, rc_ff;
  int               tl, rl;
  // decoded watermarks of the mirrored control byte
  assign tl = fc_ff[5] ? (fc_ff[4] ? DEPTH/2 : DEPTH/4) : (fc_ff[4] ? 2 : 0);
  assign rl = fc_ff[7] ? (fc_ff[6] ? DEPTH-2 : DEPTH/2) : (fc_ff[6] ? DEPTH/4 : 1);
  // mirror fill counts, saturating so dropped events stay aligned
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      fc_ff <= 8'h00;
      tc_ff <= '0;
      rc_ff <= '0;
    end else begin
      if (avs_write_i && !avs_waitrequest_o && avs_address_i == 4'h0) fc_ff <= avs_writedata_i[7:0];
      if (tx_push_i && !tx_pop_i && tc_ff != DEPTH) tc_ff <= tc_ff + 1'b1;
      if (tx_pop_i && !tx_push_i && tc_ff != 0) tc_ff <= tc_ff - 1'b1;
      if (rx_push_i && !rx_pop_i && rc_ff != DEPTH) rc_ff <= rc_ff + 1'b1;
      if (rx_pop_i && !rx_push_i && rc_ff != 0) rc_ff <= rc_ff - 1'b1;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  a_tx_ack_drop: assert property (!dma_tx_ack_n_i |=> dma_tx_req_n_o)
    else $error("tx request kept under ack");
  a_rx_ack_drop: assert property (!dma_rx_ack_n_i |=> dma_rx_req_n_o)
    else $error("rx request kept under ack");
  a_tx_req_hold: assert property (fc_ff[0] && !dma_tx_req_n_o && dma_tx_ack_n_i
    |=> !dma_tx_req_n_o) else $error("tx request dropped early");
  a_rx_req_hold: assert property (fc_ff[0] && !dma_rx_req_n_o && dma_rx_ack_n_i
    |=> !dma_rx_req_n_o) else $error("rx request dropped early");
  a_tx_level_req: assert property (fc_ff[0] && tc_ff <= tl && dma_tx_ack_n_i
    |=> !dma_tx_req_n_o) else $error("tx request missing at watermark");
  a_rx_level_req: assert property (fc_ff[0] && rc_ff >= rl && dma_rx_ack_n_i
    |=> !dma_rx_req_n_o) else $error("rx request missing at watermark");
  a_tx_single_fill: assert property (fc_ff[0]
    |=> dma_tx_single_n_o == ($past(tc_ff) == DEPTH)) else $error("tx single wrong");
  a_rx_single_fill: assert property (fc_ff[0]
    |=> dma_rx_single_n_o == ($past(rc_ff) == 0)) else $error("rx single wrong");
  a_reset_idle: assert property (disable iff (1'b0) reset_i
    |=> dma_tx_req_n_o && dma_rx_req_n_o && dma_tx_single_n_o && dma_rx_single_n_o)
    else $error("request active in reset");
  a_bus_answer: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o ##1 avs_waitrequest_o) else $error("bus answer timing wrong");
  c_back_to_back: cover property (!dma_tx_ack_n_i ##1 dma_tx_ack_n_i ##1 !dma_tx_req_n_o);
  c_rx_burst: cover property ($fell(dma_rx_req_n_o));
  c_tx_full: cover property ($rose(dma_tx_single_n_o));
endmodule // udwr_dma_req_asserts
bind udwr_dma_req udwr_dma_req_asserts #(.DEPTH(DEPTH), .CNT_W(CNT_W)) u_chk (.*);
`default_nettype wire

//--- verif/udwr_dma_ctrl_model.sv
// dma controller model serving burst requests of the uart fifos
`timescale 1ns/1ps
`default_nettype none
module udwr_dma_ctrl_model (
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  input  wire logic       tx_req_n_i,
  input  wire logic       rx_req_n_i,
  input  wire logic [4:0] dest_len_i,
  input  wire logic [4:0] src_len_i,
  input  wire logic [3:0] gap_i,
  output var  logic       tx_ack_n_o = 1'b1,
  output var  logic       rx_ack_n_o = 1'b1,
  output var  logic       tx_push_o  = 1'b0,
  output var  logic       rx_pop_o   = 1'b0,
  output var  logic       tx_err_o   = 1'b0,
  output var  logic       rx_err_o   = 1'b0
);
  // burst first, ack closes it; gap models a slow controller
  task automatic serve_tx;
    int n;
    int i;
    n = dest_len_i;
    i = 0;
    repeat (gap_i) @(posedge clk_i);
    repeat (n) begin
      tx_push_o <= 1'b1;
      @(posedge clk_i);
    end
    tx_push_o  <= 1'b0;
    tx_ack_n_o <= 1'b0;
    // request must drop soon after ack; a stuck one is flagged, not waited on
    do begin
      @(posedge clk_i);
      i++;
    end while (tx_req_n_i !== 1'b1 && i < 8);
    if (tx_req_n_i !== 1'b1) tx_err_o <= 1'b1;
    tx_ack_n_o <= 1'b1;
    @(posedge clk_i);
  endtask
  // receive side mirrors the transmit side with pops
  task automatic serve_rx;
    int n;
    int i;
    n = src_len_i;
    i = 0;
    repeat (gap_i) @(posedge clk_i);
    repeat (n) begin
      rx_pop_o <= 1'b1;
      @(posedge clk_i);
    end
    rx_pop_o   <= 1'b0;
    rx_ack_n_o <= 1'b0;
    do begin
      @(posedge clk_i);
      i++;
    end while (rx_req_n_i !== 1'b1 && i < 8);
    if (rx_req_n_i !== 1'b1) rx_err_o <= 1'b1;
    rx_ack_n_o <= 1'b1;
    @(posedge clk_i);
  endtask
  // one process per channel so every output has a single driver
  always @(posedge clk_i) if (!reset_i && tx_req_n_i === 1'b0) serve_tx();
  always @(posedge clk_i) if (!reset_i && rx_req_n_i === 1'b0) serve_rx();
endmodule // udwr_dma_ctrl_model
`default_nettype wire

//--- verif/test_uart_dma_watermark_requests.sv
// self-checking bench for the uart dma watermark request block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin mismatches++; \
  $display("wrong value at %0t: got %h exp %h", $time, a, b); end end
module test_uart_dma_watermark_requests;
  logic        clk_i = 0, reset_i = 1, avs_read_i = 0, avs_write_i = 0, avs_waitrequest_o;
  logic [3:0]  avs_address_i = 0, gap = 0;
  logic [31:0] avs_writedata_i = 0, avs_readdata_o, q;
  logic        tx_pop_i = 0, rx_push_i = 0, tx_push_i, rx_pop_i, dma_tx_ack_n_i, dma_rx_ack_n_i;
  logic        dma_tx_req_n_o, dma_rx_req_n_o, dma_tx_single_n_o, dma_rx_single_n_o;
  logic        dma_tx_err, dma_rx_err;
  logic [4:0]  tc = 0, rc = 0, dest_len = 8, src_len = 1;
  int          mismatches = 0, num_checks = 0, txl[4] = '{0, 2, 4, 8}, rxl[4] = '{1, 4, 8, 14};
  udwr_dma_req #(.DEPTH(16), .CNT_W(5)) dut (.*);
  udwr_dma_ctrl_model u_dma (.clk_i(clk_i), .reset_i(reset_i), .tx_req_n_i(dma_tx_req_n_o),
    .rx_req_n_i(dma_rx_req_n_o), .dest_len_i(dest_len), .src_len_i(src_len), .gap_i(gap),
    .tx_ack_n_o(dma_tx_ack_n_i), .rx_ack_n_o(dma_rx_ack_n_i), .tx_push_o(tx_push_i),
    .rx_pop_o(rx_pop_i), .tx_err_o(dma_tx_err), .rx_err_o(dma_rx_err));
  initial forever #2 clk_i = ~clk_i;
  task finish_test;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // one avalon access, held until waitrequest is seen low
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int i;
    {avs_address_i, avs_writedata_i, avs_write_i, avs_read_i} <= {a, d, w, !w};
    i = 0;
    do begin @(posedge clk_i); i++; end while (avs_waitrequest_o !== 1'b0 && i < 50);
    q = avs_readdata_o;
    {avs_write_i, avs_read_i} <= 2'b00;
    if (i >= 50) begin mismatches++; finish_test(); end
    // let an edge pass so a following call never reassigns the strobes in this step
    @(posedge clk_i);
  endtask
  // serialiser pops or received characters, one per cycle
  task feed(input bit rx, input logic [4:0] n);
    repeat (n) begin
      if (rx) rx_push_i <= 1'b1; else tx_pop_i <= 1'b1;
      @(posedge clk_i);
    end
    {rx_push_i, tx_pop_i} <= 2'b00;
  endtask
  task wait_ack(input bit rx, input logic v);
    int i;
    for (i = 0; i < 300 && (rx ? dma_rx_ack_n_i : dma_tx_ack_n_i) !== v; i++) @(posedge clk_i);
    if (i == 300) begin mismatches++; finish_test(); end
  endtask
  // one event short of the watermark, then at it, then one more event inside the burst, none for rx level 1
  task level_case(input bit rx, input logic [1:0] c, input int lvl);
    if (rx) begin
      src_len <= 5'(lvl);
    end else begin
      dest_len <= 5'(16 - lvl);
    end
    bus(1, 4'h0, {24'h0, rx ? {c, 6'h01} : {2'b00, c, 4'h1}});
    feed(rx, rx ? 5'(lvl - 1) - rc : tc - 5'(lvl + 1));
    repeat (3) @(posedge clk_i);
    `CHK(rx ? dma_rx_req_n_o : dma_tx_req_n_o, 1'b1)
    feed(rx, 1);
    repeat (3) @(posedge clk_i);
    `CHK(rx ? dma_rx_req_n_o : dma_tx_req_n_o, 1'b0)
    if (!rx || lvl > 1) feed(rx, 1);
    wait_ack(rx, 0);
    wait_ack(rx, 1);
    repeat (4) @(posedge clk_i);
    if (rx) rc = 5'(lvl > 1); else tc = lvl == 0 ? 5'd16 : 5'd15;
    bus(0, 4'h4, 0);
    `CHK({q[12:8], q[4:0]}, {rc, tc})
    `CHK(rx ? dma_rx_single_n_o : dma_tx_single_n_o, rx ? rc == 0 : tc == 16)
    $display("test level rx=%0d code %0d done", rx, c);
  endtask
  // reset values and an unmapped read
  task reset_case;
    bus(0, 4'h0, 0);
    `CHK(q, 32'h0)
    `CHK({dma_tx_req_n_o, dma_rx_req_n_o, dma_tx_single_n_o, dma_rx_single_n_o}, 4'hf)
    bus(0, 4'hc, 0);
    `CHK(q, 32'h0)
    $display("test reset done");
  endtask
  // half watermark from empty: two bursts fill the fifo
  task fill_case;
    bus(1, 4'h0, 32'h31);
    repeat (2) begin wait_ack(0, 0); wait_ack(0, 1); end
    tc = 16;
    `CHK(dma_tx_single_n_o, 1'b1)
    $display("test fill done");
  endtask
  // rule sized bursts leave no error flag and no stuck handshake
  task error_case;
    bus(0, 4'h8, 0);
    `CHK(q, 32'h0)
    `CHK({dma_tx_err, dma_rx_err}, 2'b00)
    $display("test error done");
  endtask
  initial begin
    repeat (4) @(posedge clk_i);
    reset_i <= 1'b0;
    reset_case();
    fill_case();
    gap <= 4'ha;
    for (int c = 3; c >= 0; c--) level_case(0, 2'(c), txl[c]);
    for (int c = 0; c < 4; c++) level_case(1, 2'(c), rxl[c]);
    error_case();
    finish_test();
  end
endmodule // test_uart_dma_watermark_requests
`default_nettype wire
